// ### verilog/line_pulse_params.svh
/*
 * constants for the line pulse timing registers: sub-addresses,
 * reset values and field layout of the high-byte registers.
 * assumes it is included by bare name from the package and top module.
 */
`ifndef LINE_PULSE_PARAMS_SVH
`define LINE_PULSE_PARAMS_SVH

// Contract
// - gain-gate start low byte at 0x08, reset 0x3f
// - gain-gate start bits 9:8 at 0x09, reset 0x03
// - gain-gate end low byte at 0x0a, reset 0x00
// - gain-gate end bits 9:8 at 0x0b, reset 0
// - line-sync start low byte at 0x0c, reset 0x3b
// - line-sync start bits 9:8 at 0x0d, reset 0x03
// - line-sync end low byte at 0x0e, reset 0x20
// - high-byte upper bits ignore writes, read zero
// - gain-gate pulse placed by start and end delays
// - active-low line-sync pin placed by delays
// - line-sync end bits 9:8 at 0x0f, reset 0

// ----------------------------------------------------------------
// sub-addresses
// ----------------------------------------------------------------
`define LP_ADDR_AGC_START_LO 8'h08
`define LP_ADDR_AGC_START_HI 8'h09
`define LP_ADDR_AGC_END_LO 8'h0a
`define LP_ADDR_AGC_END_HI 8'h0b
`define LP_ADDR_SYNC_START_LO 8'h0c
`define LP_ADDR_SYNC_START_HI 8'h0d
`define LP_ADDR_SYNC_END_LO 8'h0e
`define LP_ADDR_SYNC_END_HI 8'h0f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LP_RST_AGC_START_LO 8'h3f
`define LP_RST_AGC_START_HI 2'h3
`define LP_RST_AGC_END_LO 8'h00
`define LP_RST_AGC_END_HI 2'h0
`define LP_RST_SYNC_START_LO 8'h3b
`define LP_RST_SYNC_START_HI 2'h3
`define LP_RST_SYNC_END_LO 8'h20
`define LP_RST_SYNC_END_HI 2'h0

// ----------------------------------------------------------------
// field layout of a high-byte register
// ----------------------------------------------------------------
`define LP_HI_FIELD_W 2
`define LP_HI_PAD_W 6

`endif

// ### verilog/line_pulse_pkg.sv
/*
 * types shared by the line pulse timing block.
 * assumes line_pulse_params.svh is on the include path.
 */
`default_nettype none
`include "line_pulse_params.svh"

package line_pulse_pkg;

    // one programmed pulse: start and end delay halves
    typedef struct packed {
        logic [1:0] start_hi;
        logic [7:0] start_lo;
        logic [1:0] end_hi;
        logic [7:0] end_lo;
    } pulse_cfg_t;

    // register write request from the serial bus front end
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

`default_nettype wire

// ### verilog/line_pulse_timing_regs.sv
/*
 * timing registers and pulse generators for the gain-gate pulse and
 * the active-low line-sync output, both counted in pixel clocks.
 * assumes the serial control bus front end delivers a decoded write
 * strobe with sub-address and byte, and reads combinationally via
 * rd_addr_i with data returned registered one cycle later; the line
 * reference is a one-cycle pulse synchronous to clk_sys_i.
 */
`default_nettype none
`include "line_pulse_params.svh"

module line_pulse_timing_regs #(
    parameter int CNT_W = 10
) (
    input wire logic clk_sys_i,                     // pixel clock
    input wire logic rst_b_i,                       // async reset, low
    input wire line_pulse_pkg::reg_req_t req_i,     // write request
    input wire logic [7:0] rd_addr_i,               // read sub-address
    input wire logic line_ref_i,                    // line start pulse
    output logic [7:0] rd_data_o,                   // read byte
    output logic agc_gate_pulse_o,                  // gain-gate, high
    output logic line_sync_b_o                      // line sync, low
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    line_pulse_pkg::pulse_cfg_t agc_r, agc_nxt;
    line_pulse_pkg::pulse_cfg_t sync_r, sync_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;

    // write decode; high registers keep only bits 9:8
    always_comb begin
        agc_nxt = agc_r;
        sync_nxt = sync_r;
        if (req_i.we) begin
            unique case (req_i.addr)
                `LP_ADDR_AGC_START_LO: agc_nxt.start_lo = req_i.wdata;
                `LP_ADDR_AGC_START_HI: agc_nxt.start_hi = req_i.wdata[1:0];
                `LP_ADDR_AGC_END_LO: agc_nxt.end_lo = req_i.wdata;
                `LP_ADDR_AGC_END_HI: agc_nxt.end_hi = req_i.wdata[1:0];
                `LP_ADDR_SYNC_START_LO: sync_nxt.start_lo = req_i.wdata;
                `LP_ADDR_SYNC_START_HI: sync_nxt.start_hi = req_i.wdata[1:0];
                `LP_ADDR_SYNC_END_LO: sync_nxt.end_lo = req_i.wdata;
                `LP_ADDR_SYNC_END_HI: sync_nxt.end_hi = req_i.wdata[1:0];
                default: ;
            endcase
        end
    end

    // read mux; upper bits of high registers read zero
    always_comb begin
        rd_data_nxt = 8'h00;
        unique case (rd_addr_i)
            `LP_ADDR_AGC_START_LO: rd_data_nxt = agc_r.start_lo;
            `LP_ADDR_AGC_START_HI: rd_data_nxt = {6'h00, agc_r.start_hi};
            `LP_ADDR_AGC_END_LO: rd_data_nxt = agc_r.end_lo;
            `LP_ADDR_AGC_END_HI: rd_data_nxt = {6'h00, agc_r.end_hi};
            `LP_ADDR_SYNC_START_LO: rd_data_nxt = sync_r.start_lo;
            `LP_ADDR_SYNC_START_HI: rd_data_nxt = {6'h00, sync_r.start_hi};
            `LP_ADDR_SYNC_END_LO: rd_data_nxt = sync_r.end_lo;
            `LP_ADDR_SYNC_END_HI: rd_data_nxt = {6'h00, sync_r.end_hi};
            default: rd_data_nxt = 8'h00;
        endcase
    end

    // register storage with documented reset values
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            agc_r.start_lo <= `LP_RST_AGC_START_LO;
            agc_r.start_hi <= `LP_RST_AGC_START_HI;
            agc_r.end_lo <= `LP_RST_AGC_END_LO;
            agc_r.end_hi <= `LP_RST_AGC_END_HI;
            sync_r.start_lo <= `LP_RST_SYNC_START_LO;
            sync_r.start_hi <= `LP_RST_SYNC_START_HI;
            sync_r.end_lo <= `LP_RST_SYNC_END_LO;
            sync_r.end_hi <= `LP_RST_SYNC_END_HI;
            rd_data_r <= 8'h00;
        end else begin
            agc_r <= agc_nxt;
            sync_r <= sync_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // per-line pixel counter and pulse generation
    // ------------------------------------------------------------
    logic [CNT_W-1:0] pix_cnt_r, pix_cnt_nxt;
    logic agc_on_r, agc_on_nxt;
    logic sync_on_r, sync_on_nxt;
    logic [9:0] agc_start, agc_end, sync_start, sync_end;

    // delays are high bits over low byte, unsigned
    assign agc_start = {agc_r.start_hi, agc_r.start_lo};
    assign agc_end = {agc_r.end_hi, agc_r.end_lo};
    assign sync_start = {sync_r.start_hi, sync_r.start_lo};
    assign sync_end = {sync_r.end_hi, sync_r.end_lo};

    // counter restarts at the line reference; end match wins on a tie
    always_comb begin
        pix_cnt_nxt = line_ref_i ? '0 : pix_cnt_r + 1'b1;
        agc_on_nxt = agc_on_r;
        if (pix_cnt_nxt == CNT_W'(agc_start)) agc_on_nxt = 1'b1;
        if (pix_cnt_nxt == CNT_W'(agc_end)) agc_on_nxt = 1'b0;
        sync_on_nxt = sync_on_r;
        if (pix_cnt_nxt == CNT_W'(sync_start)) sync_on_nxt = 1'b1;
        if (pix_cnt_nxt == CNT_W'(sync_end)) sync_on_nxt = 1'b0;
    end

    // counter and pulse state
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pix_cnt_r <= '0;
            agc_on_r <= 1'b0;
            sync_on_r <= 1'b0;
        end else begin
            pix_cnt_r <= pix_cnt_nxt;
            agc_on_r <= agc_on_nxt;
            sync_on_r <= sync_on_nxt;
        end
    end

    // outputs from flip-flops; line sync is the sync flop inverted
    assign rd_data_o = rd_data_r;
    assign agc_gate_pulse_o = agc_on_r;
    assign line_sync_b_o = ~sync_on_r;

endmodule

`default_nettype wire

// ### verif/line_pulse_chk.sv
/* checker for the line pulse timing block.
   assumes binding to its top module, shadowing registers from writes. */
`default_nettype none
module line_pulse_chk #(
    parameter int CNT_W = 10
) (
    input wire logic clk_sys_i, // pixel clock
    input wire logic rst_b_i, // async reset, low
    input wire line_pulse_pkg::reg_req_t req_i, // write request
    input wire logic [7:0] rd_addr_i, // read address
    input wire logic line_ref_i, // line start
    input wire logic [7:0] rd_data_o, // read byte
    input wire logic agc_gate_pulse_o, // gain gate
    input wire logic line_sync_b_o // line sync, low
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic [7:0] sh_r [8];
    logic [CNT_W-1:0] cnt_r, cnt_nxt, as, ae, ss, se;
    // delays as counts, high bits above low byte
    assign as = CNT_W'({sh_r[1][1:0], sh_r[0]});
    assign ae = CNT_W'({sh_r[3][1:0], sh_r[2]});
    assign ss = CNT_W'({sh_r[5][1:0], sh_r[4]});
    assign se = CNT_W'({sh_r[7][1:0], sh_r[6]});
    assign cnt_nxt = line_ref_i ? '0 : cnt_r + 1'b1;
    // shadow registers and line counter
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sh_r <= '{8'h3f, 8'h03, 8'h00, 8'h00, 8'h3b, 8'h03, 8'h20, 8'h00};
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            if (req_i.we && req_i.addr[7:3] == 5'h01)
                sh_r[req_i.addr[2:0]] <= req_i.wdata;
        end
    end
    sequence s_wr; req_i.we && req_i.addr[7:3] == 5'h01; endsequence
    sequence s_rd; rd_addr_i == $past(req_i.addr) && !req_i.we; endsequence
    property p_wr_rd;
        s_wr ##1 s_rd |=> rd_data_o ==
            ($past(req_i.wdata, 2) & ($past(req_i.addr[0], 2) ? 8'h03 : 8'hff));
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("readback differs");
    property p_pad;
        rd_addr_i[7:3] == 5'h01 && rd_addr_i[0] |=> rd_data_o[7:2] == 6'h00;
    endproperty
    a_pad: assert property (p_pad) else $error("pad bits set");
    property p_agc_on; cnt_nxt == as && cnt_nxt != ae |=> agc_gate_pulse_o; endproperty
    a_agc_on: assert property (p_agc_on) else $error("gate not on");
    property p_agc_off; cnt_nxt == ae |=> !agc_gate_pulse_o; endproperty
    a_agc_off: assert property (p_agc_off) else $error("gate not off");
    property p_agc_hold;
        cnt_nxt != as && cnt_nxt != ae |=> $stable(agc_gate_pulse_o);
    endproperty
    a_agc_hold: assert property (p_agc_hold) else $error("gate moved");
    property p_sync_on; cnt_nxt == ss && cnt_nxt != se |=> !line_sync_b_o; endproperty
    a_sync_on: assert property (p_sync_on) else $error("sync not on");
    property p_sync_off; cnt_nxt == se |=> line_sync_b_o; endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync not off");
    property p_sync_hold;
        cnt_nxt != ss && cnt_nxt != se |=> $stable(line_sync_b_o);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync moved");
endmodule
`default_nettype wire

// ### verif/host_model.sv
/* host model: writes and reads timing registers.
   assumes the bench calls its tasks; inputs change at falling edges. */
`default_nettype none
module host_model (
    input wire logic clk_sys_i, // pixel clock
    input wire logic [7:0] rd_data_i, // read byte
    output var line_pulse_pkg::reg_req_t req_o, // write request
    output var logic [7:0] rd_addr_o // read address
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_o = '0;
        rd_addr_o = 8'h00;
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        req_o = {1'b1, a, d};
        @(negedge clk_sys_i);
        req_o.we = 1'b0;
    endtask
    // address set, byte taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        rd_addr_o = a;
        @(negedge clk_sys_i);
        d = rd_data_i;
    endtask
endmodule
`default_nettype wire

// ### verif/line_pulse_timing_regs_tb.sv
/* bench for the line pulse timing block with a register model.
   assumes the checker and host model are compiled before it. */
`default_nettype none
module line_pulse_timing_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, rst_b_i = 0, line_ref_i = 0, gain_control, sync_b;
    line_pulse_pkg::reg_req_t req;
    logic [7:0] rd_addr, rd_data, d;
    int n_fail = 0, n_compared = 0, seed = 86263, a, ga = 0, gs = 0;
    int mdl [17];
    int cfg [8] = '{2, 0, 5, 0, 3, 0, 7, 0};
    always #12.5 clk_sys_i = ~clk_sys_i;
    line_pulse_timing_regs #(.CNT_W(10)) i_dut (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .req_i(req), .rd_addr_i(rd_addr),
        .line_ref_i(line_ref_i), .rd_data_o(rd_data),
        .agc_gate_pulse_o(gain_control), .line_sync_b_o(sync_b));
    host_model i_host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data),
        .req_o(req), .rd_addr_o(rd_addr));
    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // write and follow in the model; high bytes keep two bits
    task automatic put(int ad, logic [7:0] dv);
        i_host.wr(ad[7:0], dv);
        if (ad > 7) mdl[ad] = ad[0] ? dv & 8'h03 : dv;
    endtask
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        mdl = '{8: 'h3f, 9: 3, 12: 'h3b, 13: 3, 14: 'h20, default: 0};
        repeat (2) @(negedge clk_sys_i);
        rst_b_i = 1;
        // reset values, unmapped reads zero
        for (a = 0; a < 17; a++) begin
            i_host.rd(a[7:0], d);
            cmp(d, mdl[a][7:0]);
        end
        // random writes with readback, random line starts
        for (int k = 0; k < 40; k++) begin
            a = $random(seed) & 15;
            d = 8'($random(seed));
            line_ref_i = d[7];
            put(a, d);
            i_host.rd(a[7:0], d);
            cmp(d, mdl[a][7:0]);
        end
        line_ref_i = 0;
        for (a = 8; a < 16; a++) put(a, cfg[a-8][7:0]);
        // two lines; second compared from a known off state
        for (int l = 0; l < 2; l++) begin
            @(negedge clk_sys_i) line_ref_i = 1;
            for (int j = 0; j < 12; j++) begin
                @(negedge clk_sys_i) line_ref_i = 0;
                ga = j == 2 ? 1 : j == 5 ? 0 : ga;
                gs = j == 3 ? 1 : j == 7 ? 0 : gs;
                if (l) cmp({gain_control, sync_b}, {ga[0], !gs[0]});
            end
        end
        conclude();
    end
endmodule
bind line_pulse_timing_regs line_pulse_chk #(.CNT_W(CNT_W)) i_chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_i(req_i),
    .rd_addr_i(rd_addr_i), .line_ref_i(line_ref_i), .rd_data_o(rd_data_o),
    .agc_gate_pulse_o(agc_gate_pulse_o), .line_sync_b_o(line_sync_b_o));
`default_nettype wire
